// [rtl/flow_fifo_pkg.sv]
// Shared constants for the pipelined flow-control FIFO.
package flow_fifo_pkg;
  localparam int unsigned DATA_WIDTH_DEF = 32;
  localparam int unsigned DEPTH_DEF      = 64;
  localparam int unsigned FLAG_STAGES    = 2;
  localparam logic        VACANT_RST     = 1'h1;
  localparam logic        FLAG_RST       = 1'h0;
  localparam logic        EMPTY_RST      = 1'h1;
endpackage : flow_fifo_pkg

// [rtl/pipelined_flow_control_fifo.sv]
// FIFO with a two-stage output skid pipeline and pipelined status flags.
//
// Functional notes
// - Words are held in storage or the output stages whenever the consumer is not taking them.
// - A word may arrive every cycle and is stored only when qualified valid.
// - An almost-full flag rises before the storage is exhausted.
// - Almost-full reaches the producer through two extra registers.
// - Depth must exceed the almost-full threshold by the stop latency.
// - Almost-full and almost-empty thresholds are configurable inputs.
// - Two cascaded skid stages; pop ripples through both load terms to the storage read.
// - Widely fanned flags are registered through pipeline stages.
// - The occupancy count is one bit wider than log2 of the depth.
// - Occupancy counts stored words plus each occupied output stage.
// - Stage loads follow vacancy and advance; storage reads when stage one loads.
// - Synchronous reset marks both output stages vacant.
`timescale 1ns/1ps
module pipelined_flow_control_fifo
  import flow_fifo_pkg::*;
#(
  parameter int unsigned DATA_WIDTH = flow_fifo_pkg::DATA_WIDTH_DEF,
  parameter int unsigned FIFO_DEPTH = flow_fifo_pkg::DEPTH_DEF,
  parameter int unsigned CW         = $clog2(FIFO_DEPTH) + 1
) (
  input  wire logic                  ref_clk,       // Clock, 125 MHz
  input  wire logic                  resetn,        // Reset, active low
  input  wire logic                  clk_en,        // Freezes state when low
  input  wire logic [DATA_WIDTH-1:0] in_data,       // Producer word
  input  wire logic                  in_valid,      // Word qualifier
  input  wire logic                  pop,           // Consumer takes word
  input  wire logic [CW-1:0]         afull_level,   // Almost-full threshold
  input  wire logic [CW-1:0]         aempty_level,  // Almost-empty threshold
  output logic                       out_valid,     // Output word valid
  output logic                       in_ready,      // Storage not full
  output logic      [DATA_WIDTH-1:0] out_data,      // Output word
  output logic      [CW-1:0]         fill_level,    // Total occupancy
  output logic                       almost_full,   // Delayed almost full
  output logic                       almost_empty,  // Delayed almost empty
  output logic                       overflow_q,    // Valid word refused
  output logic                       underflow_q    // Pop with no word
);
  logic                  rst_q;
  logic                  stage_one_vacant_q;
  logic                  stage_two_vacant_q;
  logic [DATA_WIDTH-1:0] stage_one_data_q;
  logic [DATA_WIDTH-1:0] stage_two_data_q;
  logic [DATA_WIDTH-1:0] store_head;
  logic                  store_empty;
  logic                  store_full;
  logic                  load_one;
  logic                  load_two;
  logic                  store_rd;
  logic                  store_wr;
  logic                  pop_ok;
  logic [CW-1:0]         fill_q;
  logic [CW-1:0]         fill_d;
  logic [FLAG_STAGES-1:0] afull_pipe_q;
  logic [FLAG_STAGES-1:0] aempty_pipe_q;
  logic                  afull_raw;
  logic                  aempty_raw;
  logic [CW-1:0]         afull_eff;
  logic [CW-1:0]         held_q;
  logic [CW-1:0]         held_d;

  localparam logic [CW-1:0] AFULL_CAP = CW'(FIFO_DEPTH - FLAG_STAGES);
  localparam logic [CW-1:0] DEPTH_CW  = CW'(FIFO_DEPTH);

  // Reset is sampled so that no stage flag relies on an asynchronous clear.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_q <= 1'h1;
    end else begin
      rst_q <= 1'h0;
    end
  end

  assign store_wr = in_valid && !store_full;
  assign pop_ok   = pop && !stage_two_vacant_q;
  assign load_two = stage_two_vacant_q || pop;
  assign load_one = stage_one_vacant_q || load_two;
  assign store_rd = !store_empty && load_one;

  storage_fifo #(
    .WIDTH (DATA_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_store (
    .ref_clk (ref_clk),
    .rst_q   (rst_q),
    .clk_en  (clk_en),
    .wr_en   (store_wr),
    .wr_data (in_data),
    .rd_en   (store_rd),
    .rd_data (store_head),
    .empty_q (store_empty),
    .full_q  (store_full)
  );

  always_ff @(posedge ref_clk) begin
    if (rst_q) begin
      stage_one_vacant_q <= VACANT_RST;
      stage_two_vacant_q <= VACANT_RST;
    end else if (clk_en) begin
      if (load_one) begin
        stage_one_vacant_q <= store_empty;
      end
      if (load_two) begin
        stage_two_vacant_q <= stage_one_vacant_q;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clk_en && load_one) begin
      stage_one_data_q <= store_head;
    end
    if (clk_en && load_two) begin
      stage_two_data_q <= stage_one_data_q;
    end
  end

  always_comb begin
    fill_d = fill_q;
    if (store_wr && !pop_ok) begin
      fill_d = fill_q + CW'(1);
    end else if (pop_ok && !store_wr) begin
      fill_d = fill_q - CW'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst_q) begin
      fill_q <= '0;
    end else if (clk_en) begin
      fill_q <= fill_d;
    end
  end

  // Storage occupancy is mirrored here so that ready leaves a flip-flop
  // instead of an inverter behind the storage full flag.
  always_comb begin
    held_d = held_q;
    if (store_wr && !store_rd) begin
      held_d = held_q + CW'(1);
    end else if (store_rd && !store_wr) begin
      held_d = held_q - CW'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst_q) begin
      held_q   <= '0;
      in_ready <= ~FLAG_RST;
    end else if (clk_en) begin
      held_q   <= held_d;
      in_ready <= (held_d != DEPTH_CW);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst_q) begin
      out_valid <= ~VACANT_RST;
    end else if (clk_en && load_two) begin
      out_valid <= ~stage_one_vacant_q;
    end
  end

  // threshold capped by stop margin
  // Words still in flight after the flag rises number FLAG_STAGES, so a
  // threshold above the cap would let them overrun storage.
  assign afull_eff  = (afull_level > AFULL_CAP) ? AFULL_CAP : afull_level;
  assign afull_raw  = (fill_q >= afull_eff);
  assign aempty_raw = (fill_q <= aempty_level);

  // Registering the flags trades stop latency for short routing on a
  // signal that gates many producer registers at once.
  genvar gi;
  generate
    for (gi = 0; gi < FLAG_STAGES; gi++) begin : g_flag_pipe
      logic afull_in;
      logic aempty_in;
      if (gi == 0) begin : g_head
        assign afull_in  = afull_raw;
        assign aempty_in = aempty_raw;
      end else begin : g_tail
        assign afull_in  = afull_pipe_q[gi-1];
        assign aempty_in = aempty_pipe_q[gi-1];
      end
      always_ff @(posedge ref_clk) begin
        if (rst_q) begin
          afull_pipe_q[gi]  <= FLAG_RST;
          aempty_pipe_q[gi] <= ~FLAG_RST;
        end else if (clk_en) begin
          afull_pipe_q[gi]  <= afull_in;
          aempty_pipe_q[gi] <= aempty_in;
        end
      end
    end
  endgenerate

  // Events are sticky until reset; nothing else clears them.
  always_ff @(posedge ref_clk) begin
    if (rst_q) begin
      overflow_q  <= FLAG_RST;
      underflow_q <= FLAG_RST;
    end else if (clk_en) begin
      if (in_valid && store_full) begin
        overflow_q <= 1'h1;
      end
      if (pop && stage_two_vacant_q) begin
        underflow_q <= 1'h1;
      end
    end
  end

  assign out_data     = stage_two_data_q;
  assign fill_level   = fill_q;
  assign almost_full  = afull_pipe_q[FLAG_STAGES-1];
  assign almost_empty = aempty_pipe_q[FLAG_STAGES-1];
endmodule : pipelined_flow_control_fifo

// [rtl/storage_fifo.sv]
// Flip-flop storage FIFO with first-word-fall-through read data.
`timescale 1ns/1ps
module storage_fifo
  import flow_fifo_pkg::*;
#(
  parameter int unsigned WIDTH = flow_fifo_pkg::DATA_WIDTH_DEF,
  parameter int unsigned DEPTH = flow_fifo_pkg::DEPTH_DEF,
  parameter int unsigned PW    = $clog2(DEPTH)
) (
  input  wire logic             ref_clk,  // Clock
  input  wire logic             rst_q,    // Synchronous reset, high
  input  wire logic             clk_en,   // Freezes state when low
  input  wire logic             wr_en,    // Write the word
  input  wire logic [WIDTH-1:0] wr_data,  // Word to write
  input  wire logic             rd_en,    // Drop the head word
  output logic      [WIDTH-1:0] rd_data,  // Head word
  output logic                  empty_q,  // No word held
  output logic                  full_q    // Every entry held
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_ptr_q;
  logic [PW-1:0]    rd_ptr_q;
  logic [PW:0]      count_q;
  logic [PW:0]      count_d;
  logic             do_wr;
  logic             do_rd;

  localparam logic [PW:0]   DEPTH_W = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] LAST_P  = PW'(DEPTH - 1);

  assign do_wr   = wr_en && !full_q;
  assign do_rd   = rd_en && !empty_q;
  assign rd_data = mem_q[rd_ptr_q];

  always_comb begin
    count_d = count_q;
    if (do_wr && !do_rd) begin
      count_d = count_q + (PW+1)'(1);
    end else if (do_rd && !do_wr) begin
      count_d = count_q - (PW+1)'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clk_en && do_wr) begin
      mem_q[wr_ptr_q] <= wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst_q) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
      empty_q  <= EMPTY_RST;
      full_q   <= ~EMPTY_RST;
    end else if (clk_en) begin
      if (do_wr) begin
        wr_ptr_q <= (wr_ptr_q == LAST_P) ? '0 : wr_ptr_q + PW'(1);
      end
      if (do_rd) begin
        rd_ptr_q <= (rd_ptr_q == LAST_P) ? '0 : rd_ptr_q + PW'(1);
      end
      count_q <= count_d;
      empty_q <= (count_d == '0);
      full_q  <= (count_d == DEPTH_W);
    end
  end
endmodule : storage_fifo

// [tb/flow_fifo_chk.sv]
// Port assertions for the flow-control FIFO.
`timescale 1ns/1ps
module flow_fifo_chk
  import flow_fifo_pkg::*;
#(
  parameter int unsigned DATA_WIDTH = 32,
  parameter int unsigned FIFO_DEPTH = 64,
  parameter int unsigned CW         = 7
) (
  input wire logic                  ref_clk,       // Clock
  input wire logic                  resetn,        // Reset, active low
  input wire logic                  clk_en,        // State enable
  input wire logic                  in_valid,      // Word qualifier
  input wire logic                  pop,           // Consumer take
  input wire logic [CW-1:0]         afull_level,   // Almost-full level
  input wire logic [CW-1:0]         aempty_level,  // Almost-empty level
  input wire logic [CW-1:0]         fill_level,    // Occupancy
  input wire logic [DATA_WIDTH-1:0] out_data,      // Output word
  input wire logic                  out_valid,     // Output valid
  input wire logic                  in_ready,      // Input ready
  input wire logic                  almost_full,   // Delayed flag
  input wire logic                  almost_empty,  // Delayed flag
  input wire logic                  overflow_q,    // Sticky overflow
  input wire logic                  underflow_q    // Sticky underflow
);
  localparam logic [CW-1:0] AF_CAP = CW'(FIFO_DEPTH - FLAG_STAGES);
  logic af_now;
  logic ae_now;
  // The threshold is capped so that words in flight cannot overrun.
  assign af_now = fill_level >=
                  ((afull_level > AF_CAP) ? AF_CAP : afull_level);
  assign ae_now = fill_level <= aempty_level;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence two_on;
    clk_en ##1 clk_en;
  endsequence
  sequence wr_empty;
    clk_en && in_valid && in_ready && fill_level == '0;
  endsequence
  sequence walk_on;
    wr_empty ##1 clk_en [*2];
  endsequence
  rst_state_a: assert property ($rose(resetn) |->
    !out_valid && in_ready && fill_level == '0 && almost_empty)
    else $error("state after reset wrong");
  first_out_a: assert property (walk_on |->
    !out_valid ##1 out_valid) else $error("first word latency wrong");
  fill_up_a: assert property (clk_en && in_valid && in_ready &&
    !(pop && out_valid) |=> fill_level == $past(fill_level) + 1'b1)
    else $error("fill did not rise");
  fill_dn_a: assert property (clk_en && pop && out_valid &&
    !(in_valid && in_ready) |=> fill_level == $past(fill_level) - 1'b1)
    else $error("fill did not fall");
  word_hold_a: assert property (out_valid && !(pop && clk_en) |=>
    out_valid && $stable(out_data)) else $error("output word lost");
  ovf_flag_a: assert property (clk_en && in_valid && !in_ready |=>
    overflow_q) else $error("overflow not flagged");
  udf_flag_a: assert property (clk_en && pop && !out_valid |=>
    underflow_q) else $error("underflow not flagged");
  af_level_a: assert property ((clk_en && fill_level >= afull_level)
    [*4] |-> almost_full) else $error("almost full missing");
  ae_level_a: assert property ((clk_en && fill_level <= aempty_level)
    [*4] |-> almost_empty) else $error("almost empty missing");
  ready_cap_a: assert property (!in_ready |->
    fill_level >= FIFO_DEPTH) else $error("not ready below depth");
  af_delay_a: assert property (two_on |=>
    almost_full == $past(af_now, 2)) else $error("almost full delay wrong");
  ae_delay_a: assert property (two_on |=>
    almost_empty == $past(ae_now, 2)) else $error("almost empty delay wrong");
endmodule : flow_fifo_chk
bind pipelined_flow_control_fifo flow_fifo_chk #(.DATA_WIDTH(DATA_WIDTH),
  .FIFO_DEPTH(FIFO_DEPTH), .CW(CW)) chk (.ref_clk, .resetn, .clk_en,
  .in_valid, .pop, .afull_level, .aempty_level, .fill_level, .out_data,
  .out_valid, .in_ready, .almost_full, .almost_empty, .overflow_q,
  .underflow_q);

// [tb/stream_sink.sv]
// Downstream consumer model popping with a random stall rate.
`timescale 1ns/1ps
module stream_sink (
  input  wire logic       ref_clk,    // Clock
  input  wire logic       out_valid,  // Word offered
  input  wire logic [6:0] stall_pct,  // Percent of cycles held off
  input  wire logic       bad_pop,    // Pop with nothing offered
  output logic            pop         // Take the word
);
  initial pop = 1'b0;
  always @(negedge ref_clk) begin
    pop <= (out_valid || bad_pop) && ($urandom % 100 >= stall_pct);
  end
endmodule : stream_sink

// [tb/test_pipelined_flow_control_fifo.sv]
// Self-checking bench for the pipelined flow-control FIFO.
`timescale 1ns/1ps
module test_pipelined_flow_control_fifo;
  localparam int unsigned D  = 8;
  localparam int unsigned CW = $clog2(D) + 1;
  logic ref_clk = 1'b0, resetn = 1'b0, clk_en = 1'b1, in_valid = 1'b0;
  logic bad_pop = 1'b0, pop, out_valid, in_ready, almost_full;
  logic almost_empty, overflow_q, underflow_q;
  logic [31:0] in_data = 32'h0, out_data, exp_q[$];
  logic [CW-1:0] afull_level = 4'h4, aempty_level = 4'h2, fill_level;
  logic [6:0] stall_pct = 7'h0;
  int errors = 0, cmp_count = 0, n;
  always #4 ref_clk = ~ref_clk;
  pipelined_flow_control_fifo #(.DATA_WIDTH(32), .FIFO_DEPTH(D), .CW(CW))
    dut (.ref_clk, .resetn, .clk_en, .in_data, .in_valid, .pop,
    .afull_level, .aempty_level, .out_valid, .in_ready, .out_data,
    .fill_level, .almost_full, .almost_empty, .overflow_q, .underflow_q);
  stream_sink sink (.ref_clk, .out_valid, .stall_pct, .bad_pop, .pop);
  task automatic check(input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict;
    $display("errors %0d, compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  task automatic cycles(input int k);
    repeat (k) @(negedge ref_clk);
  endtask : cycles
  task automatic do_reset;
    resetn = 1'b0;
    exp_q.delete();
    cycles(8);
    resetn = 1'b1;
    cycles(2);
    check({out_valid, in_ready, fill_level, almost_empty, overflow_q,
      underflow_q}, {2'h1, 4'h0, 3'h4});
  endtask : do_reset
  // Producer stops only on almost full, so depth must cover the lag.
  task automatic stream(input int words);
    for (n = 0; words > 0; n++) begin
      if (n > 2000) errors++;
      if (n > 2000) give_verdict();
      clk_en = ($urandom % 8) != 0;
      in_data = $urandom;
      in_valid = $urandom % 2 && !almost_full;
      if (in_valid && in_ready && clk_en) exp_q.push_back(in_data);
      if (in_valid && in_ready && clk_en) words--;
      cycles(1);
    end
    in_valid = 1'b0;
    clk_en = 1'b1;
  endtask : stream
  task automatic drain;
    stall_pct = 7'h0;
    for (n = 0; fill_level != 0; n++) begin
      if (n > 500) errors++;
      if (n > 500) give_verdict();
      cycles(1);
    end
    cycles(4);
  endtask : drain
  always @(posedge ref_clk) begin
    if (resetn && clk_en && pop && out_valid) begin
      if (exp_q.size() == 0) check(out_data, 32'hFFFFFFFF);
      else check(out_data, exp_q.pop_front());
    end
  end
  initial begin
    void'($urandom(32'h4822));
    do_reset();
    stall_pct = 7'h32;
    stream(200);
    drain();
    check(overflow_q, 1'b0);
    stall_pct = 7'h64;
    for (n = 0; in_ready && n < 20; n++) begin
      in_data = $urandom;
      in_valid = 1'b1;
      exp_q.push_back(in_data);
      cycles(1);
    end
    check(n, D + 2);
    in_valid = 1'b0;
    cycles(4);
    check({fill_level, in_ready, almost_full}, {4'hA, 2'h1});
    in_valid = 1'b1;
    cycles(1);
    in_valid = 1'b0;
    cycles(1);
    check({overflow_q, fill_level}, {1'b1, 4'hA});
    drain();
    check({almost_empty, almost_full, out_valid}, 3'h4);
    bad_pop = 1'b1;
    cycles(2);
    bad_pop = 1'b0;
    cycles(2);
    check(underflow_q, 1'b1);
    do_reset();
    afull_level = 4'hF;
    stall_pct = 7'h50;
    stream(40);
    drain();
    check(overflow_q, 1'b0);
    check(exp_q.size(), 0);
    give_verdict();
  end
endmodule : test_pipelined_flow_control_fifo
